/* File: abe_ctrl.sv */
// abe_ctrl: apb slave holding the analog block enable control register and its decode
// assumes apb master on pclk; digital sources from other clocks are synchronised here
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps

// Overview of operation
// - gate drivers locked out while driver supply is below selected threshold
// - uvlo select resets to zero for low threshold; one picks high threshold
// - one amplifier disabled: the other controls the loop, disabled one tracks
// - both amplifiers disabled: both outputs pulled low, no demand
// - both amplifier disable bits reset to zero, amplifiers enabled
// - bit 2 set disables voltage amplifier and arms overvoltage protection
// - bit 1 set disables current amplifier; clear enables it
// - select codes 1,2,3 pick pwm after monostable, pwm oscillator, timer match
// - codes 4,5,6 pick overvoltage, switch frequency, secondary pulse; 7 unused
// - bit 0 connects analog test mux output to probe pin
// - digital probe wins over analog when both enables are set
// - analog enable clear routes analog test signals to internal adc
module abe_ctrl
#(
	parameter int                  SUPPLY_W = abe_pkg::ABE_DRV_SUPPLY_W,
	parameter logic [SUPPLY_W-1:0] UVLO_LOW = 10'h0de,
	parameter logic [SUPPLY_W-1:0] UVLO_HI  = 10'h1bc
)
(
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// digital test sources
	input  wire logic                desat_out,
	input  wire logic                pwm_monostable,
	input  wire logic                pwm_oscillator,
	input  wire logic                timer_period_match,
	input  wire logic                overvoltage_compare_out,
	input  wire logic                switch_frequency_out,
	input  wire logic                secondary_on_pulse,
	// driver supply monitor
	input  wire logic [SUPPLY_W-1:0] driver_supply,
	// analog block controls
	output logic                     driver_uvlo_level_select,
	output logic                     driver_lockout,
	output logic                     current_amp_disable,
	output logic                     voltage_amp_disable,
	output logic                     ov_protect_enable,
	output logic                     current_amp_in_control,
	output logic                     voltage_amp_in_control,
	output logic                     amp_outputs_pull_low,
	// probe routing
	output logic                     digital_probe_out_enable,
	output logic [2:0]               digital_probe_select,
	output logic                     analog_probe_out_enable,
	output logic                     analog_to_probe,
	output logic                     analog_to_adc,
	output logic                     probe_pin_out,
	output logic                     probe_pin_oe
);
	import abe_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]          ctrl;
		logic [6:0]          src_s1;
		logic [6:0]          src_s2;
		logic [SUPPLY_W-1:0] sup_s1;
		logic [SUPPLY_W-1:0] sup_s2;
		abe_loop_t           loop;
		logic                cur_ctl;
		logic                volt_ctl;
		logic                pull_low;
		logic                lockout;
		logic                probe_out;
		logic                probe_oe;
		logic                an_probe;
		logic                an_adc;
		logic [31:0]         rdata;
		logic                ready;
		logic                slverr;
	} abe_state_t;

	abe_state_t st_reg;
	abe_state_t st_next;

	logic probe_sig;
	logic below;
	logic [6:0] src_raw;

	assign src_raw = {desat_out, pwm_monostable, pwm_oscillator, timer_period_match,
		overvoltage_compare_out, switch_frequency_out, secondary_on_pulse};

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// mux reads the second synchroniser stage only
	abe_probe_mux u_mux
	(
		.sel                     (st_reg.ctrl[ABE_DSEL_MSB:ABE_DSEL_LSB]),
		.desat_out               (st_reg.src_s2[6]),
		.pwm_monostable          (st_reg.src_s2[5]),
		.pwm_oscillator          (st_reg.src_s2[4]),
		.timer_period_match      (st_reg.src_s2[3]),
		.overvoltage_compare_out (st_reg.src_s2[2]),
		.switch_frequency_out    (st_reg.src_s2[1]),
		.secondary_on_pulse      (st_reg.src_s2[0]),
		.probe_sig               (probe_sig)
	);

	abe_uvlo_cmp #(
		.W        (SUPPLY_W),
		.LOW_LVL  (UVLO_LOW),
		.HIGH_LVL (UVLO_HI)
	) u_uvlo
	(
		.driver_supply (st_reg.sup_s2),
		.high_sel      (st_reg.ctrl[ABE_UVLO_SEL_BIT]),
		.below         (below)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic       setup;
		logic       mapped;
		logic [7:0] c;
		setup   = psel && !penable;
		mapped  = (paddr == ABE_CTRL_OFFSET) || (paddr == ABE_STATUS_OFFSET);
		c       = st_reg.ctrl;
		st_next = st_reg;
		st_next.src_s1 = src_raw;
		st_next.src_s2 = st_reg.src_s1;
		st_next.sup_s1 = driver_supply;
		st_next.sup_s2 = st_reg.sup_s1;

		// zero-wait-state apb: ready raised in access phase, dropped after
		st_next.ready  = setup;
		st_next.slverr = setup && !mapped;
		if (setup && !pwrite)
		begin
			if (paddr == ABE_CTRL_OFFSET)
				st_next.rdata = {24'h000000, st_reg.ctrl};
			else if (paddr == ABE_STATUS_OFFSET)
				st_next.rdata = {22'h0, st_reg.an_adc, st_reg.an_probe,
					st_reg.probe_oe, st_reg.lockout, st_reg.loop, 2'h0};
			else
				st_next.rdata = 32'h00000000;
		end
		// write lands at the completing edge
		if (psel && penable && st_reg.ready && pwrite && paddr == ABE_CTRL_OFFSET && pstrb[0])
			st_next.ctrl = pwdata[7:0];

		// decode runs off the stored value so outputs follow one edge later
		case ({c[ABE_VOLT_DIS_BIT], c[ABE_CUR_DIS_BIT]})
			2'b00:   st_next.loop = ABE_LOOP_BOTH;
			2'b01:   st_next.loop = ABE_LOOP_VOLTAGE;
			2'b10:   st_next.loop = ABE_LOOP_CURRENT;
			2'b11:   st_next.loop = ABE_LOOP_NONE;
			default: st_next.loop = ABE_LOOP_BOTH;
		endcase
		// control flags registered so the outputs leave straight from flops
		st_next.cur_ctl   = (st_next.loop == ABE_LOOP_BOTH) || (st_next.loop == ABE_LOOP_CURRENT);
		st_next.volt_ctl  = (st_next.loop == ABE_LOOP_BOTH) || (st_next.loop == ABE_LOOP_VOLTAGE);
		st_next.pull_low  = st_next.loop == ABE_LOOP_NONE;
		st_next.lockout   = below;
		st_next.an_probe  = c[ABE_ANALOG_OE_BIT] && !c[ABE_DIGITAL_OE_BIT];
		st_next.an_adc    = !c[ABE_ANALOG_OE_BIT];
		st_next.probe_oe  = c[ABE_DIGITAL_OE_BIT];
		st_next.probe_out = c[ABE_DIGITAL_OE_BIT] & probe_sig;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg      <= '0;
			st_reg.ctrl <= ABE_CTRL_RESET;
			st_reg.loop <= ABE_LOOP_BOTH;
			st_reg.an_adc <= 1'b1;
			st_reg.cur_ctl <= 1'b1;
			st_reg.volt_ctl <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// outputs, all flops
	// ----------------------------------------
	assign prdata                   = st_reg.rdata;
	assign pready                   = st_reg.ready;
	assign pslverr                  = st_reg.slverr;
	assign driver_uvlo_level_select = st_reg.ctrl[ABE_UVLO_SEL_BIT];
	assign driver_lockout           = st_reg.lockout;
	assign current_amp_disable      = st_reg.ctrl[ABE_CUR_DIS_BIT];
	assign voltage_amp_disable      = st_reg.ctrl[ABE_VOLT_DIS_BIT];
	assign ov_protect_enable        = st_reg.ctrl[ABE_VOLT_DIS_BIT];
	assign current_amp_in_control   = st_reg.cur_ctl;
	assign voltage_amp_in_control   = st_reg.volt_ctl;
	assign amp_outputs_pull_low     = st_reg.pull_low;
	assign digital_probe_out_enable = st_reg.ctrl[ABE_DIGITAL_OE_BIT];
	assign digital_probe_select     = st_reg.ctrl[ABE_DSEL_MSB:ABE_DSEL_LSB];
	assign analog_probe_out_enable  = st_reg.ctrl[ABE_ANALOG_OE_BIT];
	assign analog_to_probe          = st_reg.an_probe;
	assign analog_to_adc            = st_reg.an_adc;
	assign probe_pin_out            = st_reg.probe_out;
	assign probe_pin_oe             = st_reg.probe_oe;

endmodule : abe_ctrl

/* File: abe_ctrl_sva.sv */
// abe_ctrl_sva: port-level assertions for abe_ctrl
// assumes one pclk domain and presetn active low
`timescale 1ns/10ps
module abe_ctrl_sva
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	// decoded controls
	input wire logic        driver_uvlo_level_select,
	input wire logic        current_amp_disable,
	input wire logic        voltage_amp_disable,
	input wire logic        ov_protect_enable,
	input wire logic        current_amp_in_control,
	input wire logic        voltage_amp_in_control,
	input wire logic        amp_outputs_pull_low,
	input wire logic        digital_probe_out_enable,
	input wire logic [2:0]  digital_probe_select,
	input wire logic        analog_probe_out_enable,
	input wire logic        analog_to_probe,
	input wire logic        analog_to_adc,
	input wire logic        probe_pin_out,
	input wire logic        probe_pin_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence wr_ctrl_s;
		psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0];
	endsequence

	a_pready_pulse: assert property (setup_s |=> pready ##1 !pready)
		else $error("pready is not one pulse after setup");
	a_write_lands: assert property (wr_ctrl_s |-> ##2 {digital_probe_out_enable, digital_probe_select,
		driver_uvlo_level_select, voltage_amp_disable, current_amp_disable, analog_probe_out_enable}
		== $past(pwdata[7:0], 2))
		else $error("field outputs differ from written byte");
	a_ov_armed: assert property (ov_protect_enable == voltage_amp_disable)
		else $error("overvoltage protection not tied to voltage amp disable");
	a_cur_handoff: assert property (current_amp_in_control == $past(!current_amp_disable))
		else $error("current amp control wrong");
	a_volt_handoff: assert property (voltage_amp_in_control == $past(!voltage_amp_disable))
		else $error("voltage amp control wrong");
	a_both_pull: assert property ($rose(amp_outputs_pull_low) |-> $past(current_amp_disable && voltage_amp_disable))
		else $error("pull low without both amps disabled");
	a_probe_oe: assert property (probe_pin_oe == $past(digital_probe_out_enable))
		else $error("probe enable does not follow digital enable");
	a_probe_quiet: assert property (!probe_pin_oe |-> !probe_pin_out)
		else $error("probe pin driven while digital path off");
	a_analog_pin: assert property (analog_to_probe == $past(analog_probe_out_enable && !digital_probe_out_enable))
		else $error("analog probe route wrong");
	a_analog_adc: assert property (analog_to_adc == $past(!analog_probe_out_enable))
		else $error("analog adc route wrong");
endmodule : abe_ctrl_sva

bind abe_ctrl abe_ctrl_sva chk_u (.*);

/* File: abe_pkg.sv */
// abe_pkg: constants and types shared by the analog block enable control design
// assumes a 32-bit apb bus and an 8-bit control register in the low byte of one word
package abe_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] ABE_CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] ABE_STATUS_OFFSET = 12'h004;
	localparam logic [7:0]  ABE_CTRL_RESET    = 8'h00;

	// ----------------------------------------
	// field positions in analog_block_enable_control
	// ----------------------------------------
	localparam int ABE_ANALOG_OE_BIT  = 0;
	localparam int ABE_CUR_DIS_BIT    = 1;
	localparam int ABE_VOLT_DIS_BIT   = 2;
	localparam int ABE_UVLO_SEL_BIT   = 3;
	localparam int ABE_DSEL_LSB       = 4;
	localparam int ABE_DSEL_MSB       = 6;
	localparam int ABE_DIGITAL_OE_BIT = 7;

	// ----------------------------------------
	// digital probe select codes
	// ----------------------------------------
	localparam logic [2:0] ABE_DSEL_DESAT    = 3'h0;
	localparam logic [2:0] ABE_DSEL_PWM_MONO = 3'h1;
	localparam logic [2:0] ABE_DSEL_PWM_OSC  = 3'h2;
	localparam logic [2:0] ABE_DSEL_TMR_EQ   = 3'h3;
	localparam logic [2:0] ABE_DSEL_OV       = 3'h4;
	localparam logic [2:0] ABE_DSEL_SWFREQ   = 3'h5;
	localparam logic [2:0] ABE_DSEL_SEC_ON   = 3'h6;

	// ----------------------------------------
	// loop control modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		ABE_LOOP_BOTH    = 4'h1,
		ABE_LOOP_CURRENT = 4'h2,
		ABE_LOOP_VOLTAGE = 4'h4,
		ABE_LOOP_NONE    = 4'h8
	} abe_loop_t;

	localparam int ABE_DRV_SUPPLY_W = 10;

endpackage : abe_pkg

/* File: abe_probe_mux.sv */
// abe_probe_mux: picks one internal digital test signal by its select code
// assumes all sources are synchronous to pclk
`timescale 1ns/10ps
module abe_probe_mux
(
	// select
	input  wire logic [2:0] sel,
	// sources
	input  wire logic       desat_out,
	input  wire logic       pwm_monostable,
	input  wire logic       pwm_oscillator,
	input  wire logic       timer_period_match,
	input  wire logic       overvoltage_compare_out,
	input  wire logic       switch_frequency_out,
	input  wire logic       secondary_on_pulse,
	// result
	output logic            probe_sig
);
	import abe_pkg::*;

	always_comb
	begin
		case (sel)
			ABE_DSEL_DESAT:    probe_sig = desat_out;
			ABE_DSEL_PWM_MONO: probe_sig = pwm_monostable;
			ABE_DSEL_PWM_OSC:  probe_sig = pwm_oscillator;
			ABE_DSEL_TMR_EQ:   probe_sig = timer_period_match;
			ABE_DSEL_OV:       probe_sig = overvoltage_compare_out;
			ABE_DSEL_SWFREQ:   probe_sig = switch_frequency_out;
			ABE_DSEL_SEC_ON:   probe_sig = secondary_on_pulse;
			default:           probe_sig = 1'b0;                    // unimplemented code
		endcase
	end

endmodule : abe_probe_mux

/* File: abe_uvlo_cmp.sv */
// abe_uvlo_cmp: compares the digitised driver supply with the chosen lockout level
// assumes driver_supply is a synchronised code from an adc on pclk
`timescale 1ns/10ps
module abe_uvlo_cmp
#(
	parameter int           W        = 10,
	parameter logic [W-1:0] LOW_LVL  = 10'h0de,
	parameter logic [W-1:0] HIGH_LVL = 10'h1bc
)
(
	// inputs
	input  wire logic [W-1:0] driver_supply,
	input  wire logic         high_sel,
	// result
	output logic              below
);
	always_comb
	begin
		below = driver_supply < (high_sel ? HIGH_LVL : LOW_LVL);
	end

endmodule : abe_uvlo_cmp

/* File: analog_block_enable_control_tb.sv */
// analog_block_enable_control_tb: self-checking bench for abe_ctrl
// assumes the apb slave answers well within 20 cycles
`timescale 1ns/10ps
module analog_block_enable_control_tb;
	import abe_pkg::*;
	localparam logic [9:0] LOW = 10'h0de;
	localparam logic [9:0] HI  = 10'h1bc;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [6:0]  src;
	logic [9:0]  driver_supply;
	logic        driver_uvlo_level_select, driver_lockout, current_amp_disable, voltage_amp_disable;
	logic        ov_protect_enable, current_amp_in_control, voltage_amp_in_control, amp_outputs_pull_low;
	logic        digital_probe_out_enable, analog_probe_out_enable, analog_to_probe, analog_to_adc;
	logic        probe_pin_out, probe_pin_oe;
	logic [2:0]  digital_probe_select;
	int          bad_count, cmp_count;

	abe_ctrl #(.UVLO_LOW(LOW), .UVLO_HI(HI)) dut_u (.*, .desat_out(src[0]), .pwm_monostable(src[1]),
		.pwm_oscillator(src[2]), .timer_period_match(src[3]), .overvoltage_compare_out(src[4]),
		.switch_frequency_out(src[5]), .secondary_on_pulse(src[6]));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic give_verdict(input bit hang);
		if (hang)
			bad_count++;
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			give_verdict(1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// decoded outputs land one edge after the write, two spare
	task automatic wr(input logic [7:0] v);
		apb(1'b1, ABE_CTRL_OFFSET, {24'h0, v});
		repeat (3) @(posedge pclk);
	endtask : wr

	// inputs pass two sync flops and an output register
	task automatic settle;
		repeat (8) @(posedge pclk);
	endtask : settle

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		apb(1'b0, ABE_CTRL_OFFSET, 32'h0);
		cmp(rd, {24'h0, ABE_CTRL_RESET});
		cmp({current_amp_disable, voltage_amp_disable, driver_uvlo_level_select}, 3'b000);
		cmp({current_amp_in_control, voltage_amp_in_control, analog_to_adc, probe_pin_oe}, 4'b1110);
	endtask : t_reset

	task automatic t_amps;
		logic [7:0] v [4] = '{8'h02, 8'h04, 8'h06, 8'h00};
		logic [3:0] e [4] = '{4'b0100, 4'b1001, 4'b0011, 4'b1100};
		foreach (v[i])
		begin
			wr(v[i]);
			cmp({current_amp_in_control, voltage_amp_in_control, amp_outputs_pull_low, ov_protect_enable}, e[i]);
			cmp({voltage_amp_disable, current_amp_disable}, v[i][2:1]);
		end
	endtask : t_amps

	task automatic t_probe;
		for (int c = 0; c < 8; c++)
		begin
			wr({1'b1, c[2:0], 4'h0});
			src <= ~(7'h1 << c);
			settle();
			cmp(probe_pin_out, 1'b0);
			src <= 7'h1 << c;
			settle();
			cmp({probe_pin_oe, digital_probe_select, probe_pin_out}, {1'b1, c[2:0], c < 7});
		end
		src <= 7'h7f;
		wr(8'h60);
		settle();
		cmp({probe_pin_oe, probe_pin_out}, 2'b00);
		wr(8'h01);
		cmp({analog_to_probe, analog_to_adc}, 2'b10);
		wr(8'h81);
		cmp({analog_to_probe, analog_to_adc, probe_pin_oe, probe_pin_out}, 4'b0011);
	endtask : t_probe

	task automatic t_bus;
		wr(8'h5a);
		apb(1'b1, ABE_STATUS_OFFSET, 32'hff);
		cmp(err, 1'b0);
		pstrb <= 4'h0;
		apb(1'b1, ABE_CTRL_OFFSET, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, ABE_CTRL_OFFSET, 32'h0);
		cmp(rd, 32'h5a);
		// status: adc route on, voltage amp alone in control, no lockout at the high level
		apb(1'b0, ABE_STATUS_OFFSET, 32'h0);
		cmp(rd, 32'h210);
		apb(1'b0, 12'h008, 32'h0);
		cmp(err, 1'b1);
		cmp(rd, 32'h0);
	endtask : t_bus

	task automatic t_uvlo;
		logic [9:0] s [4] = '{LOW - 10'h1, LOW, HI - 10'h1, HI};
		logic       e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		foreach (s[i])
		begin
			wr({4'h0, i > 1, 3'h0});
			driver_supply <= s[i];
			settle();
			cmp({driver_uvlo_level_select, driver_lockout}, {i > 1, e[i]});
		end
	endtask : t_uvlo

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		src = 7'h00;
		driver_supply = HI;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_amps();
		t_probe();
		t_bus();
		t_uvlo();
		give_verdict(1'b0);
	end
endmodule : analog_block_enable_control_tb
